// ---- verilog/value_packet_regs.vh ----
// constants for the traced data value packet encoder
`ifndef VALUE_PACKET_REGS_VH
`define VALUE_PACKET_REGS_VH

// header prefixes
`define HDR_GENERAL      4'h2
`define HDR_SHORT_OFS    5'h06
`define HDR_MEDIUM_OFS   3'h2
`define HDR_TINY         6'h04
`define HDR_COMBINED     5'h03

// payload byte codes of the general packet
`define SIZE_SIX_BYTES   3'h5
`define SIZE_EIGHT_BYTES 3'h6
`define SIZE_RESERVED    3'h7

// tag width and reset value
`define TAG_WIDTH        32
`define TAG_RESET        32'h00000000
// a 32-bit tag can need five key bytes, but a key is capped at one byte
`define KEY_BYTE_MAX     4'd1

// register map (word offsets as byte addresses)
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_DATA_LO      8'h08
`define REG_DATA_HI      8'h0c
`define REG_KEY          8'h10
`define REG_TAG          8'h14
`define REG_COUNT        8'h18

// ctrl bit positions
`define CTRL_GO          0
`define CTRL_WIDE        1
`define CTRL_ADDRLESS    2
`define CTRL_CNT_LO      4
`define CTRL_FORCE_GEN   6

`endif

// ---- verilog/packet_byte_store.v ----
// small register-output memory holding the bytes of one packet
`timescale 1ns/1ps
`default_nettype none
module packet_byte_store (
	// clock and reset
	input  wire       clk_sys,
	input  wire       reset,
	// write port
	input  wire       wr_en,
	input  wire [3:0] wr_addr,
	input  wire [7:0] wr_data,
	// read port
	input  wire [3:0] rd_addr,
	output reg  [7:0] rd_data
);
	reg [7:0] mem [0:15];

	// writes store bytes; reads come out of a register
	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // packet_byte_store
`default_nettype wire

// ---- verilog/value_packet_encoder.v ----
// traced data value packet encoder with an ahb-lite register slave
// Contract
// - general packet carries up to 64 bits; header 0010, key flag, size code
// - size code 0-4 gives 0-4 bytes, 101 six, 110 eight, 111 reserved
// - size code counts payload bytes only, never the value width
// - no key flag means key is tag plus one; flag set adds key bytes
// - key bytes limited to what the tag width needs; the encoder caps keys at KEY_BYTE_MAX, one byte
// - only key bytes carry continuation bit 7; data bytes carry none
// - data bits above the emitted bytes read as zero
// - short offset packet only for values up to 16 bits with small offset
// - short selector picks +2, +3 or -1 and zero to two bytes
// - short packet value bits above sixteen are zero
// - emit only the least significant bytes needed for the value
// - medium offset packet for 32 or 64 bit values at medium offset
// - medium offset is field plus 2, or field minus 8 with range bit
// - medium byte bit selects four or eight data bytes
// - tiny packet only for values 1 to 4 at tag plus one
// - tiny header 000100 with two bit field meaning value minus one
// - combined packet header 00011, byte bit, element count
// - address-less elements are count plus one; byte bit four or eight
// - receivers never infer transfer width from byte count
`timescale 1ns/1ps
`default_nettype none
`include "value_packet_regs.vh"
module value_packet_encoder (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// trace byte stream
	output reg  [7:0]  trace_byte,
	output reg         trace_valid,
	input  wire        trace_ready
);
	localparam ST_IDLE = 2'd0;
	localparam ST_LOAD = 2'd1;
	localparam ST_SEND = 2'd2;

	reg [31:0] data_lo_r, data_hi_r, key_r, value_tag_counter_r;
	reg        wide_r, addrless_r, force_gen_r;
	reg [1:0]  addrless_elem_count_r;
	reg [15:0] pkt_count_r;
	reg [1:0]  state_r;
	reg [3:0]  len_r, idx_r;
	reg        wr_pend_r;
	reg [7:0]  addr_pend_r;
	reg        build_r;

	wire [63:0] value = {data_hi_r, data_lo_r};
	wire [31:0] ofs = key_r - value_tag_counter_r;

	// number of bytes needed for a value up to 32 bits, leading zeros dropped; eight if any bit above 31 is set
	function [3:0] need_bytes;
		input [63:0] v;
		begin
			if (v[63:32] != 32'h0) need_bytes = 4'd8;
			else if (v[31:24] != 8'h0) need_bytes = 4'd4;
			else if (v[23:16] != 8'h0) need_bytes = 4'd3;
			else if (v[15:8] != 8'h0) need_bytes = 4'd2;
			else if (v[7:0] != 8'h0) need_bytes = 4'd1;
			else need_bytes = 4'd0;
		end
	endfunction

	// general packet size code; five bytes round up to six, seven to eight, never 111
	function [2:0] size_code;
		input [63:0] v;
		reg   [3:0]  n;
		begin
			n = need_bytes(v);
			if (v[63:48] != 16'h0) size_code = `SIZE_EIGHT_BYTES;
			else if (v[47:32] != 16'h0) size_code = `SIZE_SIX_BYTES;
			else size_code = n[2:0];
		end
	endfunction

	function [3:0] code_bytes;
		input [2:0] c;
		begin
			if (c == `SIZE_EIGHT_BYTES) code_bytes = 4'd8;
			else if (c == `SIZE_SIX_BYTES) code_bytes = 4'd6;
			else code_bytes = {1'b0, c};
		end
	endfunction

	// packet assembly into byte store
	reg        wr_en;
	reg [3:0]  wr_addr;
	reg [7:0]  wr_data;
	reg [3:0]  bcnt;
	reg [2:0]  sz;
	reg [3:0]  nb;
	reg        keyed;
	reg [7:0]  hdr;
	wire [7:0] rd_data;
	reg [3:0]  rd_addr;

	// choose format and header; bytes are then written one per cycle
	always @* begin
		sz = size_code(value);
		nb = need_bytes(value);
		keyed = 1'b0;
		bcnt = 4'd0;
		hdr = 8'h00;
		if (addrless_r) begin
			hdr = {`HDR_COMBINED, wide_r, addrless_elem_count_r};
			bcnt = wide_r ? 4'd8 : 4'd4;
		end else if (!force_gen_r && ofs == 32'd1 && value >= 64'd1 && value <= 64'd4) begin
			hdr = {`HDR_TINY, value[1:0] - 2'd1};
		end else if (!force_gen_r && value[63:16] == 48'h0 && nb <= 4'd2 &&
			(ofs == 32'd2 || ofs == 32'd3 || (ofs == 32'hffffffff && nb != 4'd0))) begin
			bcnt = nb;
			if (ofs == 32'd2) hdr = {`HDR_SHORT_OFS, nb[2:0]};
			else if (ofs == 32'd3) hdr = {`HDR_SHORT_OFS, nb[2:0] + 3'd3};
			else hdr = {`HDR_SHORT_OFS, nb[2:0] + 3'd5};
		end else if (!force_gen_r && nb >= 4'd3 &&
			((ofs >= 32'd2 && ofs <= 32'd9) || ofs >= 32'hfffffff8)) begin
			// offsets 2..9 or -8..-1; byte count from the value, not the transfer
			bcnt = (nb == 4'd8) ? 4'd8 : 4'd4;
			if (ofs >= 32'd2 && ofs <= 32'd9) hdr = {`HDR_MEDIUM_OFS, bcnt[3], 1'b0, ofs[2:0] - 3'd2};
			else hdr = {`HDR_MEDIUM_OFS, bcnt[3], 1'b1, ofs[2:0]};
		end else begin
			keyed = (ofs != 32'd1);
			hdr = {`HDR_GENERAL, keyed, sz};
			bcnt = code_bytes(sz);
		end
	end

	// key bytes: 7 bits each, continuation in bit 7 on all but the last byte
	function [7:0] key_byte;
		input [31:0] k;
		input [2:0]  i;
		input [3:0]  n;
		reg   [31:0] sh;
		begin
			sh = k >> (7 * i);
			key_byte = {({1'b0, i} + 4'd1) < n, sh[6:0]};
		end
	endfunction

	// key length capped at KEY_BYTE_MAX, one byte; key bits past the cap are not sent,
	// so software must keep keys inside the implemented tag range
	function [3:0] key_len;
		input [31:0] k;
		reg   [3:0]  n;
		begin
			if (k[31:28] != 4'h0) n = 4'd5;
			else if (k[27:21] != 7'h0) n = 4'd4;
			else if (k[20:14] != 7'h0) n = 4'd3;
			else if (k[13:7] != 7'h0) n = 4'd2;
			else n = 4'd1;
			key_len = (n > `KEY_BYTE_MAX) ? `KEY_BYTE_MAX : n;
		end
	endfunction

	reg [3:0]  klen_r;
	reg [7:0]  hdr_r;
	reg [3:0]  widx_r;

	// byte writer: header, key bytes, then data low byte first
	always @* begin
		wr_en = (state_r == ST_LOAD) && (widx_r != len_r); // spare last load cycle writes nothing
		wr_addr = widx_r;
		if (widx_r == 4'd0) wr_data = hdr_r;
		else if (widx_r <= klen_r) wr_data = key_byte(key_r, widx_r[2:0] - 3'd1, klen_r);
		else wr_data = value[((widx_r - klen_r - 4'd1) * 8) +: 8];
	end

	packet_byte_store u_store (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	wire busy = (state_r != ST_IDLE);
	wire ahb_take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// the store reads one byte ahead of the stream, two ahead while a byte is taken,
	// because its read data arrive a cycle after the address
	always @* begin
		if (state_r == ST_SEND) begin
			if (trace_valid && trace_ready) rd_addr = idx_r + 4'd2;
			else rd_addr = idx_r + 4'd1;
		end else begin
			rd_addr = 4'd0;
		end
	end

	// sequencer and registers
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			data_lo_r <= 32'h0;
			data_hi_r <= 32'h0;
			key_r <= 32'h0;
			value_tag_counter_r <= `TAG_RESET;
			wide_r <= 1'b0;
			addrless_r <= 1'b0;
			force_gen_r <= 1'b0;
			addrless_elem_count_r <= 2'd0;
			pkt_count_r <= 16'h0;
			state_r <= ST_IDLE;
			len_r <= 4'd0;
			idx_r <= 4'd0;
			widx_r <= 4'd0;
			klen_r <= 4'd0;
			hdr_r <= 8'h00;
			wr_pend_r <= 1'b0;
			addr_pend_r <= 8'h00;
			build_r <= 1'b0;
			trace_valid <= 1'b0;
			trace_byte <= 8'h00;
			hrdata <= 32'h0;
		end else begin
			build_r <= 1'b0;
			wr_pend_r <= ahb_take & hwrite;
			if (ahb_take) addr_pend_r <= haddr;
			// register writes land in the data phase; ignored while busy
			if (wr_pend_r && !busy) begin
				case (addr_pend_r)
					`REG_CTRL: begin
						wide_r <= hwdata[`CTRL_WIDE];
						addrless_r <= hwdata[`CTRL_ADDRLESS];
						addrless_elem_count_r <= hwdata[`CTRL_CNT_LO +: 2];
						force_gen_r <= hwdata[`CTRL_FORCE_GEN];
						build_r <= hwdata[`CTRL_GO];
					end
					`REG_DATA_LO: data_lo_r <= hwdata;
					`REG_DATA_HI: data_hi_r <= hwdata;
					`REG_KEY: key_r <= hwdata;
					`REG_TAG: value_tag_counter_r <= hwdata;
					default: ;
				endcase
			end
			// reads answer straight from state
			if (ahb_take && !hwrite) begin
				case (haddr)
					`REG_STATUS: hrdata <= {31'h0, busy};
					`REG_DATA_LO: hrdata <= data_lo_r;
					`REG_DATA_HI: hrdata <= data_hi_r;
					`REG_KEY: hrdata <= key_r;
					`REG_TAG: hrdata <= value_tag_counter_r;
					`REG_COUNT: hrdata <= {16'h0, pkt_count_r};
					default: hrdata <= 32'h0;
				endcase
			end
			case (state_r)
				ST_IDLE: begin
					if (build_r) begin
						hdr_r <= hdr;
						klen_r <= keyed ? key_len(key_r) : 4'd0;
						len_r <= 4'd1 + (keyed ? key_len(key_r) : 4'd0) + bcnt;
						widx_r <= 4'd0;
						state_r <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					// one spare cycle after the last write lets the header reach the read register
					widx_r <= widx_r + 4'd1;
					if (widx_r == len_r) begin
						idx_r <= 4'd0;
						state_r <= ST_SEND;
					end
				end
				ST_SEND: begin
					// first cycle: rd_data holds the header read at the last load edge
					if (!trace_valid) begin
						trace_valid <= 1'b1;
						trace_byte <= rd_data;
					end else if (trace_ready) begin
						if (idx_r + 4'd1 == len_r) begin
							trace_valid <= 1'b0;
							state_r <= ST_IDLE;
							value_tag_counter_r <= addrless_r ? value_tag_counter_r + 32'd1 : key_r;
							pkt_count_r <= pkt_count_r + 16'd1;
						end else begin
							idx_r <= idx_r + 4'd1;
							trace_byte <= rd_data;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // value_packet_encoder
`default_nettype wire

// ---- verif/value_packet_monitor.sv ----
// assertions on the value packet encoder ports
`timescale 1ns/1ps
`default_nettype none
module value_packet_monitor (
	// clock, reset and bus
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// byte stream
	input wire logic [7:0]  trace_byte,
	input wire logic        trace_valid,
	input wire logic        trace_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic first_r;
	// marks the header slot: the bench starts a packet only when idle
	always_ff @(posedge clk_sys or posedge reset)
		if (reset) first_r <= 1'b0;
		else if (hsel && htrans[1] && hwrite && haddr == 8'h00) first_r <= 1'b1;
		else if (trace_valid && trace_ready) first_r <= 1'b0;
	sequence s_go; hsel && htrans[1] && hwrite && haddr == 8'h00 ##1 hwdata[0]; endsequence
	sequence s_hole; hsel && htrans[1] && !hwrite && haddr == 8'h1c; endsequence
	a_ready_always: assert property (hreadyout) else $error("wait state seen");
	a_resp_okay: assert property (!hresp) else $error("error response seen");
	a_valid_held: assert property (trace_valid && !trace_ready |=> trace_valid) else $error("byte dropped");
	a_byte_held: assert property (trace_valid && !trace_ready |=> $stable(trace_byte)) else $error("byte moved");
	a_hole_zero: assert property (s_hole |=> hrdata == 32'h0) else $error("unmapped read not zero");
	a_go_emits: assert property (s_go |-> ##[1:40] trace_valid) else $error("no packet after go");
	a_reset_idle: assert property ($fell(reset) |-> !trace_valid && hrdata == 32'h0) else $error("busy after reset");
	a_no_reserved: assert property (trace_valid && first_r && trace_byte[7:4] == 4'h2 |-> trace_byte[2:0] != 3'h7)
		else $error("reserved size code");
endmodule // value_packet_monitor
bind value_packet_encoder value_packet_monitor mon (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hreadyout, .hresp, .hrdata, .trace_byte, .trace_valid, .trace_ready);
`default_nettype wire

// ---- verif/trace_sink_model.sv ----
// trace analyzer stand-in taking packet bytes with random stalls
`timescale 1ns/1ps
`default_nettype none
module trace_sink_model (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       reset,
	// byte stream
	input wire logic [7:0] trace_byte,
	input wire logic       trace_valid,
	output var logic       trace_ready
);
	integer seed = 39;
	logic [7:0] got_q[$];
	// stalls at random so that held bytes get exercised
	always @(posedge clk_sys) begin
		if (reset) begin
			trace_ready <= 1'b0;
		end else begin
			if (trace_valid && trace_ready)
				got_q.push_back(trace_byte);
			trace_ready <= ($random(seed) & 3) != 0;
		end
	end
endmodule // trace_sink_model
`default_nettype wire

// ---- verif/tb_trace_data_value_packet_codec.sv ----
// bench for the value packet encoder with a byte-level reference model
`timescale 1ns/1ps
`default_nettype none
`include "value_packet_regs.vh"
module tb_trace_data_value_packet_codec;
	logic        clk_sys, reset, hsel, hwrite;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, q, exp_tag;
	wire logic   hreadyout, hresp, trace_valid, trace_ready;
	wire logic [31:0] hrdata;
	wire logic [7:0]  trace_byte;
	integer n_errors = 0, samples_checked = 0, seed = 39, i, n_pkts = 0;
	logic [7:0]  exp_q[$];
	value_packet_encoder dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .trace_byte(trace_byte), .trace_valid(trace_valid), .trace_ready(trace_ready));
	trace_sink_model sink (.clk_sys(clk_sys), .reset(reset), .trace_byte(trace_byte), .trace_valid(trace_valid),
		.trace_ready(trace_ready));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task end_sim;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task cmp_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
		end
	endtask
	task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
		end
	endtask
	// no fixed latency assumed: wait for ready under a bound
	task wait_rdy;
		integer j;
		j = 0;
		do begin @(posedge clk_sys); j++; end while (hreadyout !== 1'b1 && j < 20);
		if (hreadyout !== 1'b1) begin n_errors++; end_sim; end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
		wait_rdy;
		htrans <= 2'h0; hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask
	// reference encoder: priority combined, tiny, short, medium, general
	task model(input logic [31:0] t, input logic [31:0] k, input logic [63:0] v, input logic [7:0] c);
		integer d, n, j;
		logic [7:0] h;
		d = k - t;
		n = 0;
		for (j = 0; j < 8; j++) if (v[8*j+:8] != 8'h0) n = j + 1;
		exp_tag = k;
		if (c[2]) begin
			h = {5'h03, c[1], c[5:4]};
			n = c[1] ? 8 : 4;
			exp_tag = t + 1;
		end else if (!c[6] && d == 1 && v >= 1 && v <= 4) begin
			h = {6'h04, v[1:0] - 2'h1};
			n = 0;
		end else if (!c[6] && v <= 64'hffff && (d == 2 || d == 3 || (d == -1 && n != 0)))
			h = {5'h06, d == 2 ? n[2:0] : d == 3 ? n[2:0] + 3'h3 : n[2:0] + 3'h5};
		else if (!c[6] && n >= 3 && ((d >= 2 && d <= 9) || (d >= -8 && d < 0))) begin
			h = {3'h2, v[63:32] != 0, d < 0, d < 0 ? d[2:0] : d[2:0] - 3'h2};
			n = v[63:32] != 0 ? 8 : 4;
		end else begin
			if (n > 4) n = n > 6 ? 8 : 6;
			h = {4'h2, d != 1, n <= 4 ? n[2:0] : n == 6 ? 3'h5 : 3'h6};
		end
		exp_q.push_back(h);
		// keys are capped at a single key byte, so it never carries a continuation bit
		if (h[7:4] == 4'h2 && h[3]) exp_q.push_back({1'b0, k[6:0]});
		for (j = 0; j < n; j++) exp_q.push_back(v[8*j+:8]);
	endtask
	task run(input logic [31:0] t, input logic [31:0] k, input logic [63:0] v, input logic [7:0] c);
		integer j;
		bus(1'b1, `REG_TAG, t);
		bus(1'b1, `REG_DATA_LO, v[31:0]);
		bus(1'b1, `REG_DATA_HI, v[63:32]);
		bus(1'b1, `REG_KEY, k);
		model(t, k, v, c);
		bus(1'b1, `REG_CTRL, {24'h0, c | 8'h01});
		j = 0;
		do begin bus(1'b0, `REG_STATUS, 32'h0); j++; end
		while ((q[0] !== 1'b0 || sink.got_q.size() < exp_q.size()) && j < 300);
		if (q[0] !== 1'b0 || sink.got_q.size() < exp_q.size()) begin n_errors++; end_sim; end
		cmp_word(sink.got_q.size(), exp_q.size());
		while (exp_q.size() > 0 && sink.got_q.size() > 0) cmp_byte(sink.got_q.pop_front(), exp_q.pop_front());
		exp_q.delete();
		sink.got_q.delete();
		bus(1'b0, `REG_TAG, 32'h0);
		cmp_word(q, exp_tag);
		n_pkts++;
		$display("packet %0d done", n_pkts);
	endtask
	// main sequence
	initial begin
		reset = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 8'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		bus(1'b0, `REG_TAG, 32'h0);
		cmp_word(q, `TAG_RESET);
		for (i = 1; i < 5; i++) run(32'h10, 32'h11, i, 8'h0);
		run(32'h20, 32'h21, 64'h0, 8'h0);
		run(32'h30, 32'h32, 64'h1234, 8'h0);
		run(32'h30, 32'h33, 64'h56, 8'h0);
		run(32'h30, 32'h2f, 64'h9, 8'h0);
		run(32'h30, 32'h35, 64'h12345678, 8'h0);
		run(32'h30, 32'h28, 64'h100000000, 8'h0);
		run(32'h30, 32'h39, 64'h87654321, 8'h0);
		run(32'h30, 32'h30, 64'h12345678, 8'h0);
		run(32'h30, 32'h2f, 64'h0, 8'h0);
		run(32'h0, 32'h40, 64'h123456789a, 8'h0);
		run(32'h0, 32'h40, 64'h123456789abcde, 8'h0);
		for (i = 0; i < 8; i++) run(32'h50, 32'h51, 64'hdeadbeef, {2'h0, i[1:0], 2'h1, i[2], 1'b0});
		run(32'h60, 32'h61, 64'h2, 8'h40);
		for (i = 0; i < 6; i++) run($random(seed), $random(seed) & 32'h7f,
			{$random(seed), $random(seed)} >> ($random(seed) & 63), 8'h40);
		bus(1'b0, 8'h1c, 32'h0);
		cmp_word(q, 32'h0);
		bus(1'b0, `REG_COUNT, 32'h0);
		cmp_word(q, n_pkts);
		// second reset in mid-run: counter and tag return to their reset values
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		bus(1'b0, `REG_COUNT, 32'h0);
		cmp_word(q, 32'h0);
		bus(1'b0, `REG_TAG, 32'h0);
		cmp_word(q, `TAG_RESET);
		end_sim;
	end
endmodule // tb_trace_data_value_packet_codec
`default_nettype wire
